// ===== hw/ftvw_map.vh
// register map, field positions, reset values and timing figures of the fan and voltage watchdog
`ifndef FTVW_MAP_VH
`define FTVW_MAP_VH

// ************************************************************
// register offsets
// ************************************************************
`define FTVW_ADDR_CONFIG   8'h00
`define FTVW_ADDR_STAT1    8'h01
`define FTVW_ADDR_STAT2    8'h02
`define FTVW_ADDR_MASK1    8'h03
`define FTVW_ADDR_MASK2    8'h04
`define FTVW_ADDR_IDDIV    8'h05
`define FTVW_RAM_BASE      8'h20
`define FTVW_HIGH_BASE     8'h30
`define FTVW_RAM_END       8'h5F
`define FTVW_RES_OFS       6'h00
`define FTVW_HIGH_OFS      6'h10
`define FTVW_LOW_OFS       6'h20

// ************************************************************
// configuration and divisor fields
// ************************************************************
`define FTVW_CFG_START     0
`define FTVW_CFG_INT_EN    1
`define FTVW_CFG_INT_CLR   3
`define FTVW_CFG_INIT      7
`define FTVW_CFG_RST       8'h08
`define FTVW_MASK_RST      9'h000
`define FTVW_STAT_RST      9'h000
`define FTVW_DIV1_LSB      4
`define FTVW_DIV2_LSB      6
`define FTVW_DIV_RST       2'h1
`define FTVW_TACH_INPUT_FIRST_FLAG     7
`define FTVW_TACH_INPUT_SECOND_FLAG     8

// ************************************************************
// conversion slots and codes
// ************************************************************
`define FTVW_SLOT_TEMP     4'h0
`define FTVW_SLOT_TACH_INPUT_FIRST     4'h8
`define FTVW_SLOT_TACH_INPUT_SECOND     4'h9
`define FTVW_NUM_SLOTS     10
`define FTVW_CODE_NOMINAL  8'hC0
`define FTVW_CODE_FULL     8'hFF

// ************************************************************
// timing
// ************************************************************
`define FTVW_CLK_HZ        40000000
`define FTVW_OSC_HZ        22500
`define FTVW_SEQ_MS        400
`define FTVW_MS_PER_S      1000

`endif

// ===== hw/ftvw_ram.v
// value memory: conversion results and high and low watchdog limits
`timescale 1ns/1ps
module ftvw_ram
(
  input  wire       i_clock,
  input  wire       i_sys_rst,
  input  wire       i_we,
  input  wire [5:0] i_waddr,
  input  wire [7:0] i_wdata,
  input  wire [5:0] i_ra_addr,
  input  wire       i_ra_ext_sel,
  input  wire [7:0] i_ra_ext_data,
  output reg  [7:0] o_ra_data,
  input  wire [5:0] i_rb_addr,
  output reg  [7:0] o_rb_data
);

  reg [7:0] mem [0:63];

  // write port, contents are not reset
  always @(posedge i_clock)
  begin
    if (i_we)
      mem[i_waddr] <= i_wdata;
  end

  // registered read ports, port a may take outside data instead
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_ra_data <= 8'h00;
      o_rb_data <= 8'h00;
    end
    else
    begin
      o_ra_data <= i_ra_ext_sel ? i_ra_ext_data : mem[i_ra_addr];
      o_rb_data <= mem[i_rb_addr];
    end
  end

endmodule // ftvw_ram

// ===== hw/ftvw_tach.v
// fan period counter: oscillator ticks over one tach period, scaled by the divisor
`timescale 1ns/1ps
`include "ftvw_map.vh"
module ftvw_tach
(
  input  wire       i_clock,
  input  wire       i_sys_rst,
  input  wire       i_osc_tick,
  input  wire       i_tach,
  input  wire [1:0] i_div_sel,
  output reg  [7:0] o_count
);

  reg        tach_d;
  reg        armed;
  reg  [1:0] pre;
  reg  [7:0] cnt;
  wire       rise      = i_tach & ~tach_d;
  // slower divisors thin the ticks, divide by 1 counts each tick twice
  wire [1:0] skip      = (i_div_sel == 2'h3) ? 2'h3 : (i_div_sel == 2'h2) ? 2'h1 : 2'h0;
  wire       tick_en   = i_osc_tick && ((pre & skip) == 2'h0);
  wire [8:0] step      = (i_div_sel == 2'h0) ? 9'h002 : 9'h001;  // [RQ7] [RQ8]
  wire [8:0] sum       = {1'b0, cnt} + step;
  wire [7:0] next_cnt  = sum[8] ? `FTVW_CODE_FULL : sum[7:0];  // saturates at 255 [RQ6] [RQ12]
  wire [7:0] first_cnt = tick_en ? step[7:0] : 8'h00;  // tick on the edge belongs to the new period

  // count scaled ticks between two rising edges
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      tach_d  <= 1'b0;
      armed   <= 1'b0;
      pre     <= 2'h0;
      cnt     <= 8'h00;
      o_count <= 8'h00;
    end
    else
    begin
      tach_d <= i_tach;
      if (i_osc_tick)
        pre <= pre + 2'h1;
      if (rise && !armed)
      begin
        armed <= 1'b1;  // first edge opens the gate
        cnt   <= first_cnt;
      end
      else if (rise)
      begin
        o_count <= cnt;  // one tach period [RQ5] [RQ8]
        cnt     <= first_cnt;
      end
      else if (tick_en)
        cnt <= next_cnt;
    end
  end

endmodule // ftvw_tach

// ===== hw/ftvw_top.v
// fan tachometer and supply voltage watchdog: registers, sequencer, comparators and alert
// Behaviour
// (RQ1) each supply input is converted to an unsigned 8-bit code kept as its result.
// (RQ2) code 192 is three-quarter scale (nominal rail) and 255 is full scale.
// (RQ3) a code above the high limit or at or below the low limit sets that input's status flag.
// (RQ4) a set flag asserts the alert only while its mask bit is zero.
// (RQ5) each fan counts 22.5 kHz oscillator pulses over one tach period.
// (RQ6) the fan counter is 8 bits wide, largest value 255.
// (RQ7) each fan has a divisor of 1, 2, 4 or 8 in the ident and divisor register, 2 after reset.
// (RQ8) the fan count equals 1.35e6 over rpm times divisor for two-pulse fans.
// (RQ9) the two fan divisors are programmed independently.
// (RQ10) software should treat 70 percent speed, count 219 at divisor 2, as a fan failure.
// (RQ11) software should double the divisor for one-pulse fans.
// (RQ12) a too-long tach period saturates the counter instead of wrapping.
// (RQ13) once started, the block cycles temperature, seven voltages and two fans about every 400 ms.
// (RQ14) the alert pin is driven only while configuration bit 1 is high.
// (RQ15) configuration bit 3 releases the alert and halts monitoring, keeping status flags.
`timescale 1ns/1ps
`include "ftvw_map.vh"
module ftvw_top
#(
  parameter SLOT_CYCLES = (`FTVW_SEQ_MS * (`FTVW_CLK_HZ / `FTVW_MS_PER_S)) / `FTVW_NUM_SLOTS,
  parameter [3:0] IDENT = 4'h5  // arbitrary identification value
)
(
  input  wire       i_clock,
  input  wire       i_sys_rst,
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wr_data,
  input  wire       i_wr_stb,
  input  wire       i_rd_stb,
  output wire [7:0] o_rd_data,
  input  wire       i_tach_input_first,
  input  wire       i_tach_input_second,
  input  wire [7:0] i_adc_code,
  input  wire       i_adc_done,
  output reg        o_adc_start,
  output reg  [3:0] o_adc_channel,
  output reg        o_irq,
  output reg        o_alert_n,
  output reg        o_alert_oe
);

  // ************************************************************
  // constants
  // ************************************************************
  localparam [31:0] SLOT_LAST = SLOT_CYCLES - 1;
  localparam [31:0] OSC_DIV   = `FTVW_CLK_HZ / `FTVW_OSC_HZ;
  localparam [31:0] OSC_LAST  = OSC_DIV - 1;
  localparam [5:0] S_IDLE  = 6'h01;
  localparam [5:0] S_WAIT  = 6'h02;
  localparam [5:0] S_CONV  = 6'h04;
  localparam [5:0] S_RDHI  = 6'h08;
  localparam [5:0] S_RDLO  = 6'h10;
  localparam [5:0] S_STORE = 6'h20;

  // ************************************************************
  // control registers
  // ************************************************************
  reg  [7:0]  cfg;
  reg  [8:0]  stat;
  reg  [8:0]  mask;
  reg  [1:0]  div1;
  reg  [1:0]  div2;
  reg  [8:0]  flag_set;
  reg  [8:0]  next_stat;
  wire        run;
  wire        wr_cfg;
  wire        do_init;
  wire [8:0]  stat_clr;
  wire [8:0]  pending;

  // monitoring only while started and not held by clear
  assign run     = cfg[`FTVW_CFG_START] & ~cfg[`FTVW_CFG_INT_CLR];  // [RQ15]
  assign wr_cfg  = i_wr_stb && i_addr == `FTVW_ADDR_CONFIG;
  assign do_init = wr_cfg && i_wr_data[`FTVW_CFG_INIT];
  assign pending = stat & ~mask;  // [RQ4]

  // reads of a status register clear its bits
  assign stat_clr[7:0] = (i_rd_stb && i_addr == `FTVW_ADDR_STAT1) ? 8'hFF : 8'h00;
  assign stat_clr[8]   = i_rd_stb && i_addr == `FTVW_ADDR_STAT2;

  // new events win over a clear in the same cycle
  always @*
  begin
    next_stat = (stat & ~stat_clr) | flag_set;
  end

  // configuration, masks and divisors with self-clearing initialise bit
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cfg  <= `FTVW_CFG_RST;
      stat <= `FTVW_STAT_RST;
      mask <= `FTVW_MASK_RST;
      div1 <= `FTVW_DIV_RST;  // divide by 2 [RQ7]
      div2 <= `FTVW_DIV_RST;
    end
    else if (do_init)
    begin
      cfg  <= `FTVW_CFG_RST;
      stat <= `FTVW_STAT_RST;
      mask <= `FTVW_MASK_RST;
      div1 <= `FTVW_DIV_RST;
      div2 <= `FTVW_DIV_RST;
    end
    else
    begin
      stat <= next_stat;  // flags survive a halt [RQ15]
      if (wr_cfg)
      begin
        cfg <= i_wr_data;
        cfg[`FTVW_CFG_INIT] <= 1'b0;
      end
      if (i_wr_stb && i_addr == `FTVW_ADDR_MASK1)
        mask[7:0] <= i_wr_data;
      if (i_wr_stb && i_addr == `FTVW_ADDR_MASK2)
        mask[8] <= i_wr_data[0];
      if (i_wr_stb && i_addr == `FTVW_ADDR_IDDIV)
      begin
        div1 <= i_wr_data[`FTVW_DIV1_LSB +: 2];  // independent fields [RQ9]
        div2 <= i_wr_data[`FTVW_DIV2_LSB +: 2];
      end
    end
  end

  // ************************************************************
  // register read path
  // ************************************************************
  reg  [7:0] ctrl_rd;
  wire       in_ram;
  wire [7:0] ram_ofs;
  wire       ram_wr_bus;

  assign in_ram     = i_addr >= `FTVW_RAM_BASE && i_addr <= `FTVW_RAM_END;
  assign ram_ofs    = i_addr - `FTVW_RAM_BASE;
  assign ram_wr_bus = i_wr_stb && i_addr >= `FTVW_HIGH_BASE && i_addr <= `FTVW_RAM_END;

  // control register mux, unmapped addresses read zero
  always @*
  begin
    ctrl_rd = 8'h00;
    if (i_rd_stb)
    begin
      case (i_addr)
        `FTVW_ADDR_CONFIG: ctrl_rd = cfg;
        `FTVW_ADDR_STAT1:  ctrl_rd = stat[7:0];
        `FTVW_ADDR_STAT2:  ctrl_rd = {7'h00, stat[8]};
        `FTVW_ADDR_MASK1:  ctrl_rd = mask[7:0];
        `FTVW_ADDR_MASK2:  ctrl_rd = {7'h00, mask[8]};
        `FTVW_ADDR_IDDIV:  ctrl_rd = {div2, div1, IDENT};
        default:           ctrl_rd = 8'h00;
      endcase
    end
  end

  // ************************************************************
  // fan oscillator and period counters
  // ************************************************************
  reg  [10:0] osc_cnt;
  reg         osc_tick;
  wire [7:0]  tach_input_first_count;
  wire [7:0]  tach_input_second_count;

  // 22.5 kHz enable pulse from the system clock
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      osc_cnt  <= 11'h000;
      osc_tick <= 1'b0;
    end
    else if (osc_cnt == OSC_LAST[10:0])
    begin
      osc_cnt  <= 11'h000;
      osc_tick <= 1'b1;  // [RQ5]
    end
    else
    begin
      osc_cnt  <= osc_cnt + 11'h001;
      osc_tick <= 1'b0;
    end
  end

  ftvw_tach u_tach_input_first
  (
    .i_clock    (i_clock),
    .i_sys_rst  (i_sys_rst),
    .i_osc_tick (osc_tick),
    .i_tach     (i_tach_input_first),
    .i_div_sel  (div1),
    .o_count    (tach_input_first_count)
  );

  ftvw_tach u_tach_input_second
  (
    .i_clock    (i_clock),
    .i_sys_rst  (i_sys_rst),
    .i_osc_tick (osc_tick),
    .i_tach     (i_tach_input_second),
    .i_div_sel  (div2),
    .o_count    (tach_input_second_count)
  );

  // ************************************************************
  // round-robin sequencer
  // ************************************************************
  reg  [5:0]  state;
  reg  [3:0]  slot;
  reg  [20:0] timer;
  reg  [7:0]  code;
  reg  [7:0]  hi_lim;
  wire [7:0]  rb_data;
  wire [5:0]  rb_addr;
  wire        is_fan;
  wire        viol;

  assign is_fan  = slot == `FTVW_SLOT_TACH_INPUT_FIRST || slot == `FTVW_SLOT_TACH_INPUT_SECOND;
  // low limit stays selected through a stalled store
  assign rb_addr = (state == S_RDLO || state == S_STORE) ? (`FTVW_LOW_OFS + {2'b00, slot})
                                                         : (`FTVW_HIGH_OFS + {2'b00, slot});
  // window compare, fans only have a high limit
  assign viol    = (code > hi_lim) || (!is_fan && code <= rb_data);  // [RQ3]

  // step through the slots, one per period
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      state         <= S_IDLE;
      slot          <= `FTVW_SLOT_TEMP;
      timer         <= 21'h000000;
      code          <= 8'h00;
      hi_lim        <= 8'h00;
      flag_set      <= 9'h000;
      o_adc_start   <= 1'b0;
      o_adc_channel <= `FTVW_SLOT_TEMP;
    end
    else
    begin
      o_adc_start <= 1'b0;
      flag_set    <= 9'h000;
      if (!run || do_init)
      begin
        state <= S_IDLE;  // halt, flags untouched [RQ15]
        timer <= 21'h000000;
      end
      else
      begin
        case (state)
          S_IDLE:
            state <= S_WAIT;
          S_WAIT:
            if (timer == SLOT_LAST[20:0])
            begin
              timer <= 21'h000000;
              if (is_fan)
              begin
                code  <= (slot == `FTVW_SLOT_TACH_INPUT_FIRST) ? tach_input_first_count : tach_input_second_count;
                state <= S_RDHI;
              end
              else
              begin
                o_adc_start   <= 1'b1;
                o_adc_channel <= slot;
                state         <= S_CONV;
              end
            end
            else
              timer <= timer + 21'h000001;
          S_CONV:
            if (i_adc_done)
            begin
              code  <= i_adc_code;  // 8-bit result, 0xC0 nominal [RQ1] [RQ2]
              state <= (slot == `FTVW_SLOT_TEMP) ? S_STORE : S_RDHI;
            end
          S_RDHI:
            state <= S_RDLO;
          S_RDLO:
          begin
            hi_lim <= rb_data;
            state  <= S_STORE;
          end
          S_STORE:
            if (!i_wr_stb)
            begin
              if (slot != `FTVW_SLOT_TEMP && viol)
                flag_set[slot - 4'h1] <= 1'b1;  // [RQ3]
              slot  <= (slot == `FTVW_SLOT_TACH_INPUT_SECOND) ? `FTVW_SLOT_TEMP : slot + 4'h1;  // [RQ13]
              state <= S_WAIT;
            end
          default:
            state <= S_IDLE;
        endcase
      end
    end
  end

  // ************************************************************
  // value memory
  // ************************************************************
  wire       seq_we  = run && state == S_STORE && !i_wr_stb;
  wire       ram_we  = ram_wr_bus || seq_we;
  wire [5:0] ram_wa  = ram_wr_bus ? ram_ofs[5:0] : (`FTVW_RES_OFS + {2'b00, slot});
  wire [7:0] ram_wd  = ram_wr_bus ? i_wr_data : code;

  ftvw_ram u_ram
  (
    .i_clock       (i_clock),
    .i_sys_rst     (i_sys_rst),
    .i_we          (ram_we),
    .i_waddr       (ram_wa),
    .i_wdata       (ram_wd),
    .i_ra_addr     (ram_ofs[5:0]),
    .i_ra_ext_sel  (!(i_rd_stb && in_ram)),
    .i_ra_ext_data (ctrl_rd),
    .o_ra_data     (o_rd_data),
    .i_rb_addr     (rb_addr),
    .o_rb_data     (rb_data)
  );

  // ************************************************************
  // interrupt and alert outputs
  // ************************************************************
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_irq      <= 1'b0;
      o_alert_n  <= 1'b1;
      o_alert_oe <= 1'b0;
    end
    else
    begin
      o_irq      <= |pending;  // [RQ4]
      // pin pulled low only while enabled and not cleared
      o_alert_oe <= cfg[`FTVW_CFG_INT_EN] & ~cfg[`FTVW_CFG_INT_CLR] & (|pending);  // [RQ14] [RQ15]
      o_alert_n  <= ~(cfg[`FTVW_CFG_INT_EN] & ~cfg[`FTVW_CFG_INT_CLR] & (|pending));
    end
  end

endmodule // ftvw_top

// ===== tb/ftvw_chk.sv
// port checker of the fan and voltage watchdog
`timescale 1ns/1ps
`include "ftvw_map.vh"
module ftvw_chk
#(
  parameter SLOT_CYCLES = 20
)
(
  input wire       i_clock,
  input wire       i_sys_rst,
  input wire [7:0] i_addr,
  input wire [7:0] i_wr_data,
  input wire       i_wr_stb,
  input wire       i_rd_stb,
  input wire [7:0] o_rd_data,
  input wire       o_adc_start,
  input wire [3:0] o_adc_channel,
  input wire       o_irq,
  input wire       o_alert_n,
  input wire       o_alert_oe
);
  localparam int GAP_MAX = 8 * (SLOT_CYCLES + 40);
  reg  [7:0]  cfg;
  reg  [2:0]  last_ch;
  reg         seen;
  reg  [15:0] gap;
  wire        cfg_wr = i_wr_stb && (i_addr == `FTVW_ADDR_CONFIG);
  wire        run    = cfg[0] && !cfg[3];
  // shadow configuration, last channel and cycles since a start
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cfg     <= `FTVW_CFG_RST;
      seen    <= 1'b0;
      last_ch <= 3'h0;
      gap     <= 16'h0000;
    end
    else
    begin
      if (cfg_wr)
        cfg <= i_wr_data[7] ? `FTVW_CFG_RST : i_wr_data;
      if (cfg_wr && i_wr_data[7])
        seen <= 1'b0;
      else if (o_adc_start)
        seen <= 1'b1;
      if (o_adc_start)
        last_ch <= o_adc_channel[2:0];
      gap <= (o_adc_start || !run) ? 16'h0000 : gap + 16'h0001;
    end
  end
  // ************************************************************
  // properties
  // ************************************************************
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence s_launch;
    o_adc_start ##1 !o_adc_start;
  endsequence
  property p_rd_idle;
    !i_rd_stb |=> (o_rd_data == 8'h00);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_alert_pair;
    o_alert_oe == !o_alert_n;
  endproperty
  a_alert_pair: assert property (p_alert_pair) else $error("alert level and enable disagree");
  property p_alert_cause;
    o_alert_oe |-> o_irq;
  endproperty
  a_alert_cause: assert property (p_alert_cause) else $error("alert without unmasked flag");
  property p_alert_cfg;
    o_alert_oe |-> ($past(cfg[1] && !cfg[3]) || $past(cfg[1] && !cfg[3], 2));
  endproperty
  a_alert_cfg: assert property (p_alert_cfg) else $error("alert driven while disabled");
  property p_halt_idle;
    o_adc_start |-> $past(run);
  endproperty
  a_halt_idle: assert property (p_halt_idle) else $error("conversion while halted");
  property p_start_pulse;
    o_adc_start |-> s_launch;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
  property p_start_slot;
    o_adc_start |-> (o_adc_channel <= 4'h7);
  endproperty
  a_start_slot: assert property (p_start_slot) else $error("start on a fan slot");
  property p_round_robin;
    o_adc_start && seen |-> (o_adc_channel[2:0] == last_ch + 3'h1) || (o_adc_channel[2:0] == last_ch);
  endproperty
  a_round_robin: assert property (p_round_robin) else $error("slot order broken");
  property p_chan_hold;
    !o_adc_start && !$past(cfg_wr && i_wr_data[7]) |-> $stable(o_adc_channel);
  endproperty
  a_chan_hold: assert property (p_chan_hold) else $error("channel moved without start");
  property p_gap;
    gap < GAP_MAX;
  endproperty
  a_gap: assert property (p_gap) else $error("sequencer stalled");
endmodule // ftvw_chk

bind ftvw_top ftvw_chk #(.SLOT_CYCLES(SLOT_CYCLES)) u_chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst),
  .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_stb(i_wr_stb), .i_rd_stb(i_rd_stb), .o_rd_data(o_rd_data),
  .o_adc_start(o_adc_start), .o_adc_channel(o_adc_channel), .o_irq(o_irq), .o_alert_n(o_alert_n),
  .o_alert_oe(o_alert_oe));

// ===== tb/ftvw_far.sv
// far side model: supply converter and two fan tachometers
`timescale 1ns/1ps
module ftvw_far
(
  input  wire       i_clock,
  input  wire       i_sys_rst,
  input  wire       i_adc_start,
  input  wire [3:0] i_adc_channel,
  output reg  [7:0] o_adc_code,
  output reg        o_adc_done,
  output reg        o_tach_first,
  output reg        o_tach_second
);
  reg [7:0] codes [0:7];  // code per slot
  reg [3:0] ch;
  integer   dly;          // conversion latency
  integer   half1;        // tach half periods, 0 stops the fan
  integer   half2;
  integer   cnt;
  integer   t1;
  integer   t2;
  // idle fans, prompt converter
  initial
  begin
    dly = 2;
    half1 = 0;
    half2 = 0;
    t1 = 0;
    t2 = 0;
    ch = 4'h0;
    o_tach_first = 1'b0;
    o_tach_second = 1'b0;
  end
  // converter: one done pulse per start, code churns outside it
  always @(posedge i_clock or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_adc_done <= 1'b0;
      o_adc_code <= 8'hA5;
      cnt        <= -1;
    end
    else
    begin
      o_adc_done <= (cnt == 0);
      o_adc_code <= (cnt == 0) ? codes[ch[2:0]] : ~o_adc_code;
      if (i_adc_start)
      begin
        ch  <= i_adc_channel;
        cnt <= dly;
      end
      else if (cnt >= 0)
        cnt <= cnt - 1;
    end
  end
  // tach square waves
  always @(posedge i_clock)
  begin
    t1 <= (t1 + 1 >= half1) ? 0 : t1 + 1;
    t2 <= (t2 + 1 >= half2) ? 0 : t2 + 1;
    if (half1 != 0 && t1 + 1 >= half1)
      o_tach_first <= ~o_tach_first;
    if (half2 != 0 && t2 + 1 >= half2)
      o_tach_second <= ~o_tach_second;
  end
endmodule // ftvw_far

// ===== tb/testbench.sv
// self-checking bench of the fan and voltage watchdog
`timescale 1ns/1ps
`include "ftvw_map.vh"
module testbench;
  localparam [3:0] ID = 4'h5;  // arbitrary identification value
  localparam       FP = 6 * (`FTVW_CLK_HZ / `FTVW_OSC_HZ);
  localparam       E1 = (45000 * FP + `FTVW_CLK_HZ / 2) / `FTVW_CLK_HZ;
  reg        clk;
  reg        rst;
  reg  [7:0] addr;
  reg  [7:0] wdat;
  reg        ws;
  reg        rs;
  wire [7:0] rdat;
  wire [7:0] code;
  wire [3:0] chan;
  wire       t1, t2, done, start, irq, al_n, al_oe;
  reg  [24:0] rows [0:6];  // code, high, low, flag
  reg  [15:0] lim;
  reg  [7:0]  rv;
  reg  [7:0]  st;
  integer     fail_count;
  integer     n_tests;
  integer     i;
  integer     k;
  // 40 MHz clock
  always #12.5 clk = ~clk;
  ftvw_top #(.SLOT_CYCLES(20), .IDENT(ID)) uut (.i_clock(clk), .i_sys_rst(rst), .i_addr(addr),
    .i_wr_data(wdat), .i_wr_stb(ws), .i_rd_stb(rs), .o_rd_data(rdat), .i_tach_input_first(t1),
    .i_tach_input_second(t2), .i_adc_code(code), .i_adc_done(done), .o_adc_start(start),
    .o_adc_channel(chan), .o_irq(irq), .o_alert_n(al_n), .o_alert_oe(al_oe));
  ftvw_far far (.i_clock(clk), .i_sys_rst(rst), .i_adc_start(start), .i_adc_channel(chan),
    .o_adc_code(code), .o_adc_done(done), .o_tach_first(t1), .o_tach_second(t2));
  // ************************************************************
  // tasks
  // ************************************************************
  task chk(input [7:0] got, input [7:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      fail_count = fail_count + 1;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask
  task wr(input [7:0] a, input [7:0] d);
  begin
    @(posedge clk);
    addr <= a;
    wdat <= d;
    ws   <= 1'b1;
    @(posedge clk);
    ws   <= 1'b0;
  end
  endtask
  task rd(input [7:0] a);
  begin
    @(posedge clk);
    addr <= a;
    rs   <= 1'b1;
    @(posedge clk);
    rs   <= 1'b0;
    #1 rv = rdat;
  end
  endtask
  task watch(input integer n, input integer need);
    integer c;
  begin
    k = 0;
    for (c = 0; c < n && (need == 0 || k < need); c = c + 1)
    begin
      @(posedge clk);
      #1;
      if (start === 1'b1)
        k = k + 1;
    end
    if (need > 0 && k < need)
    begin
      chk(8'h00, 8'h01);
      final_report;
    end
  end
  endtask
  task final_report;
  begin
    $display("tests %0d failures %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    addr = 8'h00;
    wdat = 8'h00;
    ws = 1'b0;
    rs = 1'b0;
    fail_count = 0;
    n_tests = 0;
    rows[0] = {8'hC1, 8'hC0, 8'h10, 1'b1};
    rows[1] = {8'hC0, 8'hC0, 8'h10, 1'b0};
    rows[2] = {8'h10, 8'hFF, 8'h10, 1'b1};
    rows[3] = {8'h11, 8'hFF, 8'h10, 1'b0};
    rows[4] = {8'hFF, 8'hFE, 8'h00, 1'b1};
    rows[5] = {8'hFF, 8'hFF, 8'h00, 1'b0};
    rows[6] = {8'h00, 8'hFF, 8'h00, 1'b1};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk({4'h0, irq, al_n, al_oe, start}, 8'h04);
    for (i = 0; i < 6; i = i + 1)
    begin
      rd(i[7:0]);
      chk(rv, (i == 0) ? `FTVW_CFG_RST : (i == 5) ? {`FTVW_DIV_RST, `FTVW_DIV_RST, ID} : 8'h00);
    end
    rd(8'h10);
    chk(rv, 8'h00);
    wr(`FTVW_ADDR_IDDIV, 8'h1F);
    rd(`FTVW_ADDR_IDDIV);
    chk(rv, {2'h0, 2'h1, ID});
    wr(`FTVW_ADDR_CONFIG, 8'h80);
    rd(`FTVW_ADDR_IDDIV);
    chk(rv, {2'h1, 2'h1, ID});
    $display("test reset done");
    // limits for every slot, converter codes for slots 0 to 7, rows on the voltage slots
    for (i = 0; i < 10; i = i + 1)
    begin
      lim = (i > 0 && i < 8) ? rows[i - 1][16:1] : 16'hFF00;
      if (i < 8)
        far.codes[i] = (i > 0) ? rows[i - 1][24:17] : 8'h20;
      wr(`FTVW_HIGH_BASE + i[7:0], lim[15:8]);
      wr(8'h40 + i[7:0], lim[7:0]);
    end
    wr(`FTVW_ADDR_CONFIG, 8'h03);
    watch(5000, 20);
    chk({5'h0, irq, al_n, al_oe}, 8'h05);
    wr(`FTVW_ADDR_CONFIG, 8'h0B);
    wr(8'h21, 8'h00);
    watch(300, 0);
    chk({5'h0, irq, al_n, al_oe}, 8'h06);
    chk(k[7:0], 8'h00);
    rd(`FTVW_ADDR_STAT1);
    st = rv;
    for (i = 0; i < 7; i = i + 1)
    begin
      chk({7'h0, st[i]}, {7'h0, rows[i][0]});
      rd(8'h21 + i[7:0]);
      chk(rv, rows[i][24:17]);
    end
    rd(`FTVW_ADDR_STAT1);
    chk(rv, 8'h00);
    @(posedge clk);
    #1 chk({7'h0, irq}, 8'h00);
    $display("test voltage rows done");
    // masked flags, slow converter, then alert output disabled
    wr(`FTVW_ADDR_MASK1, 8'hFF);
    far.dly = 30;
    wr(`FTVW_ADDR_CONFIG, 8'h03);
    watch(5000, 20);
    chk({6'h0, irq, al_oe}, 8'h00);
    wr(`FTVW_ADDR_MASK1, 8'h00);
    wr(`FTVW_ADDR_CONFIG, 8'h01);
    watch(5000, 10);
    chk({6'h0, irq, al_oe}, 8'h02);
    $display("test mask and enable done");
    // fans at one speed, divisors 1 and 2
    wr(`FTVW_ADDR_CONFIG, 8'h09);
    wr(`FTVW_ADDR_IDDIV, 8'h40);
    wr(`FTVW_HIGH_BASE + 8'h08, 8'h03);
    wr(`FTVW_HIGH_BASE + 8'h09, 8'hDB);
    far.half1 = FP / 2;
    far.half2 = FP; // one pulse per turn, doubled divisor
    wr(`FTVW_ADDR_CONFIG, 8'h03);
    watch(40000, 0);
    wr(`FTVW_ADDR_CONFIG, 8'h0B);
    rd(`FTVW_RAM_BASE + 8'h08);
    chk({7'h0, rv >= E1 - 1 && rv <= E1 + 1}, 8'h01);
    rd(`FTVW_RAM_BASE + 8'h09);
    chk({7'h0, rv >= E1 - 1 && rv <= E1 + 1}, 8'h01);
    rd(`FTVW_ADDR_STAT1);
    chk({7'h0, rv[7]}, 8'h01);
    rd(`FTVW_ADDR_STAT2);
    chk(rv, 8'h00);
    // fan one at divide by 4
    wr(`FTVW_ADDR_IDDIV, 8'h60);
    wr(`FTVW_ADDR_CONFIG, 8'h03);
    watch(25000, 0);
    wr(`FTVW_ADDR_CONFIG, 8'h0B);
    rd(`FTVW_RAM_BASE + 8'h08);
    chk({7'h0, rv >= E1 / 4 - 1 && rv <= E1 / 4 + 1}, 8'h01);
    $display("test fans done");
    final_report;
  end
endmodule // testbench
